// [rtl/clbi_map.vh]
// constants for the cpu local bus interface: state codes, status encodings, reset values.
// assumes inclusion by clbi_bus_interface.v and the bench; definitions only, no logic.
`ifndef CLBI_MAP_VH
`define CLBI_MAP_VH

// ==========================================
// bus states, one processor clock each
`define CLBI_ST_IDLE 2'h0
`define CLBI_ST_STATUS 2'h1
`define CLBI_ST_COMMAND 2'h2
`define CLBI_ST_HOLD 2'h3

// ==========================================
// operation types carried on reqType
`define CLBI_OP_MEM_RD 3'h0
`define CLBI_OP_MEM_WR 3'h1
`define CLBI_OP_IO_RD 3'h2
`define CLBI_OP_IO_WR 3'h3
`define CLBI_OP_INTA 3'h4
`define CLBI_OP_HALT 3'h5

// ==========================================
// segment selects on reqSeg
`define CLBI_SEG_CS 2'h0
`define CLBI_SEG_DS 2'h1
`define CLBI_SEG_ES 2'h2
`define CLBI_SEG_SS 2'h3

// ==========================================
// lane codes: word on both lanes, byte on low lane, byte on high lane
`define CLBI_LANE_WORD 2'h0
`define CLBI_LANE_LOW 2'h1
`define CLBI_LANE_HIGH 2'h2

// ==========================================
// status pin encodings {statusHiN, statusLoN}
`define CLBI_STS_IDLE 2'h3
`define CLBI_STS_READ 2'h2
`define CLBI_STS_WRITE 2'h1
`define CLBI_STS_SPECIAL 2'h0

// ==========================================
// reset values and fixed figures
`define CLBI_CS_RESET 16'hF000
`define CLBI_IP_RESET 16'hFFF0
`define CLBI_TOP_HIGH 4'hF
`define CLBI_TOP_LOW 4'h0
`define CLBI_VEC_DOUBLE 8'h08
`define CLBI_SHUTDOWN_ADDR 24'h000002
`define CLBI_ADDR_ZERO 24'h000000

`endif

// [rtl/clbi_bus_interface.v]
// local bus interface of a 16-bit processor: request fifo, bus state machine, fault tracking.
// assumes ref_clk is the double-rate system clock; bus pins and ready/hold/nmi come from outside.
//
// Function
// - two exceptions in one instruction raise the double fault, vector 8.
// - an exception during double fault handling enters shutdown, announced by halt with address bit 1 high.
// - shutdown ends on nmi keeping protected mode, or on reset returning to real mode.
// - after reset code references in real mode drive the top address nibble high until cs reload.
// - in real mode, data, extra and stack references drive the top address nibble to zero.
// - after a cs reload in real mode code references drive the nibble low.
// - reset sets code segment F000 and instruction pointer FFF0.
// - 24-bit addresses in protected mode, 20-bit in real mode, little-endian words.
// - even bytes on low lane, odd bytes on high lane, even words on both.
// - odd word splits into two operations, high lane first then low lane.
// - lane encoding by address bit 0 and upper byte enable.
// - 64K i/o addresses, odd on high lane, even on low lane.
// - system clock divided by two into phase 1 and phase 2.
// - six operation types: memory and i/o read and write, acknowledge, halt.
// - bus is idle, status, command or hold, one processor clock each.
// - status lines go low in status state with address and write data.
// - command state repeats as wait states until ready is seen.
// - bus request enters hold, floats address, data, status, asserts grant.
// - pipelined start of a new operation every two processor clocks.
// - current address stays valid through phase 1 of the first command state.
// - after a write with hold pending spend one idle clock before hold.
`timescale 1ns/100ps
`include "clbi_map.vh"

// ==========================================
// request fifo
module clbi_req_fifo #(
	parameter WIDTH = 46,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire ref_clk, // system clock
	input wire arst_n, // async reset, active low
	input wire inValid, // producer has a word
	output reg inReady, // fifo can take a word
	input wire [WIDTH-1:0] inData, // word in
	output reg outValid, // fifo holds a word
	input wire outReady, // consumer takes the word
	output wire [WIDTH-1:0] outData // head word
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr;
	reg [AW-1:0] rdPtr;
	reg [AW:0] count;
	wire push;
	wire pop;
	reg [AW:0] next_count;

	assign push = inValid & inReady;
	assign pop = outValid & outReady;
	assign outData = mem[rdPtr];

	always @*
	begin
		next_count = count;
		if (push & ~pop)
			next_count = count + 1'b1;
		else if (pop & ~push)
			next_count = count - 1'b1;
	end

	always @(posedge ref_clk)
	begin
		if (push)
			mem[wrPtr] <= inData;
	end

	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wrPtr <= {AW{1'b0}};
			rdPtr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			inReady <= 1'b1;
			outValid <= 1'b0;
		end
		else
		begin
			// pointers wrap naturally when DEPTH is a power of two
			if (push)
				wrPtr <= wrPtr + 1'b1;
			if (pop)
				rdPtr <= rdPtr + 1'b1;
			count <= next_count;
			inReady <= (next_count != DEPTH[AW:0]);
			outValid <= (next_count != {(AW+1){1'b0}});
		end
	end
endmodule

// ==========================================
// top
module clbi_bus_interface #(
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire ref_clk, // double-rate system clock
	input wire arst_n, // async reset, active low
	input wire reqValid, // core bus request
	output wire reqReady, // request accepted
	input wire [2:0] reqType, // operation type
	input wire [1:0] reqSeg, // segment used
	input wire reqWord, // word rather than byte
	input wire [23:0] reqAddr, // offset-added address
	input wire [15:0] reqData, // write data
	output reg rdValid, // read data pulse
	output reg [15:0] rdData, // read data
	input wire excEvent, // exception detected pulse
	input wire instrDone, // instruction boundary pulse
	input wire csReload, // code segment reloaded pulse
	input wire [15:0] csLoadValue, // new code segment
	input wire peSet, // enter protected mode pulse
	input wire nmiIn, // nonmaskable interrupt pin
	output reg faultValid, // fault vector pulse
	output reg [7:0] faultVector, // fault vector number
	output reg shutdown, // in shutdown
	output reg protMode, // protected mode
	output reg [15:0] codeSeg, // code segment
	output reg [15:0] instructionPointer, // initial fetch pointer
	output reg processorPhase2, // phase 2 of processor clock
	output reg [23:0] addrOut, // address pins
	output reg upper_byte_enable_n, // upper lane enable
	output reg cycle_status_hi_n, // status line high
	output reg cycle_status_lo_n, // status line low
	output reg memIo, // memory, not i/o
	output reg codeInta, // code or not acknowledge
	output reg busOe, // address and status enable
	input wire [15:0] dataIn, // data pins in
	output reg [15:0] dataOut, // data pins out
	output reg dataOe, // data pins enable
	input wire readyIn_n, // ready pin, active low
	input wire holdReq, // bus request pin
	output reg hold_grant_out // hold acknowledge
);
	localparam FW = 46;

	// ==========================================
	// pin synchronisers
	reg holdMeta, holdSync, readyMeta_n, readySync_n, nmiMeta, nmiSync, nmiPrev;
	reg [15:0] dataMeta, dataSync;

	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			holdMeta <= 1'b0;
			holdSync <= 1'b0;
			readyMeta_n <= 1'b1;
			readySync_n <= 1'b1;
			nmiMeta <= 1'b0;
			nmiSync <= 1'b0;
			nmiPrev <= 1'b0;
			dataMeta <= 16'h0000;
			dataSync <= 16'h0000;
		end
		else
		begin
			holdMeta <= holdReq;
			holdSync <= holdMeta;
			readyMeta_n <= readyIn_n;
			readySync_n <= readyMeta_n;
			nmiMeta <= nmiIn;
			nmiSync <= nmiMeta;
			nmiPrev <= nmiSync;
			// data takes the same delay as ready so both are seen together
			dataMeta <= dataIn;
			dataSync <= dataMeta;
		end
	end

	// ==========================================
	// request fifo
	wire fifoValid;
	wire [FW-1:0] fifoData;
	reg fifoPop;
	wire fifoReady;

	clbi_req_fifo #(.WIDTH(FW), .DEPTH(DEPTH), .AW(AW)) reqFifo (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.inValid(reqValid),
		.inReady(fifoReady),
		.inData({reqType, reqSeg, reqWord, reqAddr, reqData}),
		.outValid(fifoValid),
		.outReady(fifoPop),
		.outData(fifoData)
	);
	assign reqReady = fifoReady;

	// ==========================================
	// fault tracking and modes
	reg excSeen, dblActive, sdPending, csFresh;

	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			excSeen <= 1'b0;
			dblActive <= 1'b0;
			shutdown <= 1'b0;
			faultValid <= 1'b0;
			faultVector <= 8'h00;
			protMode <= 1'b0;
			csFresh <= 1'b1;
			codeSeg <= `CLBI_CS_RESET;
			instructionPointer <= `CLBI_IP_RESET;
		end
		else
		begin
			faultValid <= 1'b0;
			if (peSet)
				protMode <= 1'b1;
			if (csReload)
			begin
				csFresh <= 1'b0;
				codeSeg <= csLoadValue;
			end
			if (shutdown)
			begin
				if (nmiSync & ~nmiPrev)
					shutdown <= 1'b0;
			end
			else if (excEvent)
			begin
				if (dblActive)
				begin
					shutdown <= 1'b1;
					dblActive <= 1'b0;
					excSeen <= 1'b0;
				end
				else if (excSeen)
				begin
					dblActive <= 1'b1;
					faultValid <= 1'b1;
					faultVector <= `CLBI_VEC_DOUBLE;
				end
				else
					excSeen <= 1'b1;
			end
			else if (instrDone)
			begin
				excSeen <= 1'b0;
				dblActive <= 1'b0;
			end
		end
	end

	// ==========================================
	// next operation selection
	reg busPending;
	reg [2:0] opType;
	reg [23:0] opAddr;
	reg [1:0] opLane;
	reg [15:0] opData;
	reg opSplit;
	reg splitPending;
	reg [2:0] curType;
	reg [23:0] curAddr;
	reg [15:0] curData;
	reg [1:0] curLane;
	reg curFirst;
	reg curJoin;
	wire [2:0] fType = fifoData[45:43];
	wire [1:0] fSeg = fifoData[42:41];
	wire fWord = fifoData[40];
	wire [23:0] fAddr = fifoData[39:16];
	wire [15:0] fData = fifoData[15:0];
	wire fMem = (fType == `CLBI_OP_MEM_RD) | (fType == `CLBI_OP_MEM_WR);
	wire fIo = (fType == `CLBI_OP_IO_RD) | (fType == `CLBI_OP_IO_WR);
	reg [3:0] topNibble;

	always @*
	begin
		// real mode reaches one megabyte, the top nibble is forced
		topNibble = `CLBI_TOP_LOW;
		if (fSeg == `CLBI_SEG_CS && csFresh)
			topNibble = `CLBI_TOP_HIGH;
		busPending = sdPending | splitPending | (fifoValid & ~shutdown);
		opType = fType;
		opAddr = fAddr;
		opLane = `CLBI_LANE_WORD;
		opData = fData;
		opSplit = 1'b0;
		if (sdPending)
		begin
			opType = `CLBI_OP_HALT;
			opAddr = `CLBI_SHUTDOWN_ADDR;
			opLane = `CLBI_LANE_LOW;
		end
		else if (splitPending)
		begin
			opType = curType;
			opAddr = curAddr + 24'h000001;
			opLane = `CLBI_LANE_LOW;
			opData = {8'h00, curData[15:8]};
		end
		else
		begin
			if (fMem && !protMode)
				opAddr = {topNibble, fAddr[19:0]};
			else if (fIo)
				opAddr = {8'h00, fAddr[15:0]};
			else if (!fMem)
				opAddr = {fAddr[23:2], 1'b0, 1'b0};
			if (fType == `CLBI_OP_INTA || fType == `CLBI_OP_HALT)
				opLane = `CLBI_LANE_LOW;
			else if (fAddr[0])
			begin
				opLane = `CLBI_LANE_HIGH;
				opData = {fData[7:0], 8'h00};
				opSplit = fWord;
			end
			else if (!fWord)
				opLane = `CLBI_LANE_LOW;
		end
	end

	wire opWrite = (opType == `CLBI_OP_MEM_WR) | (opType == `CLBI_OP_IO_WR);
	wire curWrite = (curType == `CLBI_OP_MEM_WR) | (curType == `CLBI_OP_IO_WR);

	// ==========================================
	// bus state machine, stepped at the end of phase 2
	reg [1:0] busState;
	reg readySeen;
	reg writeTail;
	reg [7:0] lowHalf;
	reg next_load;

	always @*
	begin
		next_load = 1'b0;
		if (processorPhase2 && !holdSync && busPending)
		begin
			if (busState == `CLBI_ST_IDLE)
				next_load = 1'b1;
			else if (busState == `CLBI_ST_COMMAND && readySeen)
				next_load = 1'b1;
		end
		fifoPop = next_load & ~sdPending & ~splitPending;
	end

	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			processorPhase2 <= 1'b0;
			busState <= `CLBI_ST_IDLE;
			readySeen <= 1'b0;
			writeTail <= 1'b0;
			sdPending <= 1'b0;
			splitPending <= 1'b0;
			curType <= `CLBI_OP_MEM_RD;
			curAddr <= `CLBI_ADDR_ZERO;
			curData <= 16'h0000;
			curLane <= `CLBI_LANE_WORD;
			curFirst <= 1'b0;
			curJoin <= 1'b0;
			lowHalf <= 8'h00;
			rdValid <= 1'b0;
			rdData <= 16'h0000;
			addrOut <= `CLBI_ADDR_ZERO;
			upper_byte_enable_n <= 1'b1;
			{cycle_status_hi_n, cycle_status_lo_n} <= `CLBI_STS_IDLE;
			memIo <= 1'b1;
			codeInta <= 1'b1;
			busOe <= 1'b1;
			dataOut <= 16'h0000;
			dataOe <= 1'b0;
			hold_grant_out <= 1'b0;
		end
		else
		begin
			processorPhase2 <= ~processorPhase2;
			rdValid <= 1'b0;
			if (excEvent & dblActive & ~shutdown)
				sdPending <= 1'b1;
			if (writeTail)
			begin
				// write data is held one system clock past the last command state
				writeTail <= 1'b0;
				dataOe <= 1'b0;
			end
			if (!processorPhase2)
			begin
				if (busState == `CLBI_ST_COMMAND)
					readySeen <= ~readySync_n;
				if (busState == `CLBI_ST_STATUS && curWrite)
					dataOe <= 1'b1;
			end
			else
			begin
				{cycle_status_hi_n, cycle_status_lo_n} <= `CLBI_STS_IDLE;
				case (busState)
				`CLBI_ST_IDLE:
					if (holdSync)
					begin
						busState <= `CLBI_ST_HOLD;
						busOe <= 1'b0;
						dataOe <= 1'b0;
						hold_grant_out <= 1'b1;
					end
					else if (next_load)
						busState <= `CLBI_ST_STATUS;
				`CLBI_ST_STATUS:
					busState <= `CLBI_ST_COMMAND;
				`CLBI_ST_COMMAND:
					if (readySeen)
					begin
						readySeen <= 1'b0;
						// a halt carries no data, so it must not report a read
						if (!curWrite && curType != `CLBI_OP_HALT)
						begin
							if (curFirst)
								lowHalf <= dataSync[15:8];
							else
							begin
								rdValid <= 1'b1;
								if (curJoin)
									rdData <= {dataSync[7:0], lowHalf};
								else if (curLane == `CLBI_LANE_HIGH)
									rdData <= {8'h00, dataSync[15:8]};
								else if (curLane == `CLBI_LANE_LOW)
									rdData <= {8'h00, dataSync[7:0]};
								else
									rdData <= dataSync;
							end
						end
						if (next_load)
							busState <= `CLBI_ST_STATUS;
						else if (holdSync && !curWrite)
						begin
							busState <= `CLBI_ST_HOLD;
							busOe <= 1'b0;
							hold_grant_out <= 1'b1;
						end
						else
							busState <= `CLBI_ST_IDLE;
						if (curWrite && !(next_load && opWrite))
							writeTail <= 1'b1;
					end
				`CLBI_ST_HOLD:
					if (!holdSync)
					begin
						busState <= `CLBI_ST_IDLE;
						busOe <= 1'b1;
						hold_grant_out <= 1'b0;
					end
				default:
					busState <= `CLBI_ST_IDLE;
				endcase
				if (next_load && (busState != `CLBI_ST_IDLE || !holdSync))
				begin
					// new address appears at the start of status, after phase 2 of the last command state
					if (sdPending)
						sdPending <= 1'b0;
					curType <= opType;
					curAddr <= opAddr;
					curData <= splitPending ? curData : fData;
					curLane <= opLane;
					curFirst <= opSplit;
					// second half is claimed at the first load, so a queued request cannot slip in between
					splitPending <= opSplit;
					curJoin <= splitPending;
					addrOut <= opAddr;
					upper_byte_enable_n <= (opLane == `CLBI_LANE_LOW);
					dataOut <= opData;
					memIo <= ~(opType == `CLBI_OP_IO_RD || opType == `CLBI_OP_IO_WR || opType == `CLBI_OP_INTA);
					codeInta <= ~(opType == `CLBI_OP_INTA || opType == `CLBI_OP_HALT);
					if (opType == `CLBI_OP_MEM_RD || opType == `CLBI_OP_IO_RD)
						{cycle_status_hi_n, cycle_status_lo_n} <= `CLBI_STS_READ;
					else if (opWrite)
						{cycle_status_hi_n, cycle_status_lo_n} <= `CLBI_STS_WRITE;
					else
						{cycle_status_hi_n, cycle_status_lo_n} <= `CLBI_STS_SPECIAL;
				end
			end
		end
	end
endmodule

// [bench/clbi_checker.sv]
// checker: bus state and pin assertions on the top ports of the bus interface.
// assumes one clock, ref_clk, and the async reset arst_n.
`timescale 1ns/100ps
// ==========================================
// checker
module clbi_checker (
	input wire ref_clk, // clock
	input wire arst_n, // reset
	input wire holdReq, // hold request
	input wire processorPhase2, // phase
	input wire [23:0] addrOut, // address
	input wire upper_byte_enable_n, // upper lane
	input wire cycle_status_hi_n, // status
	input wire cycle_status_lo_n, // status
	input wire busOe, // bus drive
	input wire dataOe, // data drive
	input wire hold_grant_out, // grant
	input wire shutdown, // shutdown
	input wire faultValid, // fault pulse
	input wire [7:0] faultVector // vector
);
	wire stsAct;
	assign stsAct = !(cycle_status_hi_n && cycle_status_lo_n);
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	sequence opStart;
		$rose(stsAct);
	endsequence
	sequence haltSd;
		stsAct && !cycle_status_hi_n && !cycle_status_lo_n && addrOut == 24'h000002;
	endsequence
	phase_toggle_a: assert property ($past(arst_n) |-> processorPhase2 != $past(processorPhase2))
		else $error("phase stuck");
	status_len_a: assert property (opStart |=> stsAct ##1 !stsAct)
		else $error("status length");
	status_phase_a: assert property (opStart |-> !processorPhase2)
		else $error("status not in phase 1");
	addr_hold_a: assert property (opStart |=> $stable(addrOut) [*2])
		else $error("address moved early");
	hold_float_a: assert property (hold_grant_out |-> !busOe && !dataOe)
		else $error("driving in hold");
	hold_grant_a: assert property ($rose(holdReq) |-> ##[1:80] hold_grant_out)
		else $error("no grant");
	write_gap_a: assert property ($fell(dataOe) |-> !hold_grant_out)
		else $error("no idle before hold");
	halt_sd_a: assert property ($rose(shutdown) |-> ##[1:40] haltSd)
		else $error("no shutdown halt");
	fault_vec_a: assert property (faultValid |-> faultVector == 8'h08)
		else $error("bad vector");
	lane_enc_a: assert property (stsAct |-> !(addrOut[0] && upper_byte_enable_n))
		else $error("no lane");
endmodule

bind clbi_bus_interface clbi_checker u_chk (.*);

// [bench/clbi_mem_model.sv]
// model: memory and i/o responder on the local bus, with ready and an ack vector.
// assumes the status, address and data pins of the bus interface, one clock.
`timescale 1ns/100ps
// ==========================================
// responder
module clbi_mem_model (
	input wire ref_clk, // clock
	input wire arst_n, // reset
	input wire [3:0] waits, // wait states asked
	input wire [23:0] addrOut, // address
	input wire upper_byte_enable_n, // upper lane
	input wire cycle_status_hi_n, // status
	input wire cycle_status_lo_n, // status
	input wire [15:0] dataOut, // write data
	input wire dataOe, // write drive
	output reg readyIn_n, // ready, low active
	output reg [15:0] dataIn // read data
);
	reg [15:0] mem [0:15];
	reg [4:0] cnt;
	reg wrOp;
	reg stsPrev;
	integer i;
	wire stsAct;
	wire [3:0] idx;
	assign stsAct = !(cycle_status_hi_n && cycle_status_lo_n);
	assign idx = addrOut[4:1];
	initial
		for (i = 0; i < 16; i = i + 1)
			mem[i] = 16'h5A00 | i[15:0];
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt <= 5'h00;
			wrOp <= 1'h0;
			stsPrev <= 1'h0;
			readyIn_n <= 1'h1;
			dataIn <= 16'h0000;
		end
		else
		begin
			stsPrev <= stsAct;
			// pulled up: a two-cycle low pulse ends a slow operation, zero waits keeps it low
			readyIn_n <= !(waits == 4'h0 || cnt == 5'h01 || cnt == 5'h02);
			if (cnt != 5'h00)
				cnt <= cnt - 5'h01;
			// one write per operation, while its own address and data still stand
			if (wrOp && dataOe)
			begin
				wrOp <= 1'h0;
				if (!addrOut[0])
					mem[idx][7:0] <= dataOut[7:0];
				if (!upper_byte_enable_n)
					mem[idx][15:8] <= dataOut[15:8];
			end
			if (stsAct && !stsPrev)
			begin
				cnt <= {waits, 1'h0} + 5'h02;
				wrOp <= !cycle_status_hi_n;
				if (cycle_status_hi_n)
					dataIn <= mem[idx];
				else if (!cycle_status_lo_n)
					dataIn <= 16'h0042;
				else
					dataIn <= ~dataIn;
			end
		end
	end
endmodule

// [bench/clbi_bus_interface_bench.sv]
// bench: drives core requests and pins, checks answers against the responder model.
// assumes the design and header from rtl/, the model and checker from bench/.
`timescale 1ns/100ps
`include "clbi_map.vh"
// ==========================================
// bench
module clbi_bus_interface_bench;
	typedef struct {logic [2:0] t; logic [1:0] s; logic w; logic [23:0] a;
		logic [15:0] d; logic [15:0] e; logic [3:0] top; logic [1:0] ln; logic rd;} clbi_row_t;
	reg ref_clk, arst_n = '0, reqValid = '0, reqWord = '0, excEvent = '0, instrDone = '0;
	reg csReload = '0, peSet = '0, nmiIn = '0, holdReq = '0;
	reg [2:0] reqType = '0;
	reg [1:0] reqSeg = '0;
	reg [23:0] reqAddr = '0;
	reg [15:0] reqData = '0, csLoadValue = '0;
	reg [3:0] waits = '0;
	wire reqReady, rdValid, faultValid, shutdown, protMode, processorPhase2, upper_byte_enable_n;
	wire cycle_status_hi_n, cycle_status_lo_n, memIo, codeInta, busOe, dataOe, readyIn_n, hold_grant_out;
	wire [15:0] rdData, codeSeg, instructionPointer, dataIn, dataOut;
	wire [7:0] faultVector;
	wire [23:0] addrOut;
	integer opCount = 0, faultCount = 0, cyc = 0, err_total = 0, num_checks = 0, i, base, lat0;
	reg [23:0] lastAddr = '0;
	reg lastUbe = '0, stsPrev = '0, lastMio = '0, lastCi = '0;
	wire stsAct = !(cycle_status_hi_n && cycle_status_lo_n);
	clbi_row_t r;
	clbi_row_t rows [0:11];
	clbi_bus_interface #(.DEPTH(8), .AW(3)) u_dut (.*);
	clbi_mem_model u_mem (.*);
	initial
	begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		stsPrev <= stsAct;
		if (faultValid)
			faultCount <= faultCount + 1;
		if (stsAct && !stsPrev)
		begin
			opCount <= opCount + 1;
			lastAddr <= addrOut;
			lastUbe <= upper_byte_enable_n;
			lastMio <= memIo;
			lastCi <= codeInta;
		end
		if (cyc == 30000)
		begin
			err_total = err_total + 1;
			tally_and_finish;
		end
	end
	// ==========================================
	// tasks
	task tally_and_finish;
	begin
		if (err_total == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	task chk(input logic ok, input string msg);
	begin
		num_checks = num_checks + 1;
		if (ok !== 1'h1)
		begin
			err_total = err_total + 1;
			$display("wrong value at %0t: %s", $time, msg);
		end
	end
	endtask
	function automatic logic cond(input integer k, input integer t);
		case (k)
			0: cond = rdValid === 1'h1;
			1: cond = hold_grant_out === 1'h1;
			2: cond = opCount >= t;
			3: cond = shutdown === 1'h1;
			4: cond = shutdown === 1'h0;
			default: cond = faultCount >= t;
		endcase
	endfunction
	task waitFor(input integer k, input integer t);
		integer n;
	begin
		n = 0;
		while (!cond(k, t) && n < 400)
		begin
			@(negedge ref_clk);
			n = n + 1;
		end
		chk(n < 400, "wait timed out");
	end
	endtask
	// request held until the edge that takes it, released at the next falling edge
	task send(input [2:0] t, input [1:0] s, input w, input [23:0] a, input [15:0] d);
	begin
		@(negedge ref_clk);
		reqValid = 1'h1;
		reqType = t;
		reqSeg = s;
		reqWord = w;
		reqAddr = a;
		reqData = d;
		while (reqReady !== 1'h1)
			@(negedge ref_clk);
		@(negedge ref_clk);
		reqValid = 1'h0;
	end
	endtask
	task readAt(input [1:0] s, input [23:0] a);
	begin
		send(`CLBI_OP_MEM_RD, s, 1'h1, a, 16'h0000);
		waitFor(0, 0);
	end
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		rows = '{'{3'h1, 2'h1, 1'h1, 24'h000004, 16'h1234, 16'h0000, 4'h0, 2'h0, 1'h0},
			'{3'h0, 2'h1, 1'h1, 24'h000004, 16'h0000, 16'h1234, 4'h0, 2'h0, 1'h1},
			'{3'h1, 2'h2, 1'h0, 24'h000007, 16'h00AB, 16'h0000, 4'h0, 2'h2, 1'h0},
			'{3'h0, 2'h3, 1'h0, 24'h000007, 16'h0000, 16'h00AB, 4'h0, 2'h2, 1'h1},
			'{3'h0, 2'h1, 1'h0, 24'h700004, 16'h0000, 16'h0034, 4'h0, 2'h1, 1'h1},
			'{3'h1, 2'h1, 1'h1, 24'h000009, 16'hBEEF, 16'h0000, 4'h0, 2'h1, 1'h0},
			'{3'h0, 2'h2, 1'h1, 24'h000009, 16'h0000, 16'hBEEF, 4'h0, 2'h1, 1'h1},
			'{3'h3, 2'h1, 1'h0, 24'h000021, 16'h0077, 16'h0000, 4'h0, 2'h2, 1'h0},
			'{3'h2, 2'h1, 1'h0, 24'h000021, 16'h0000, 16'h0077, 4'h0, 2'h2, 1'h1},
			'{3'h4, 2'h1, 1'h1, 24'h000000, 16'h0000, 16'h0042, 4'h0, 2'h1, 1'h1},
			'{3'h0, 2'h0, 1'h1, 24'h000010, 16'h0000, 16'h5A08, 4'hF, 2'h0, 1'h1},
			'{3'h5, 2'h1, 1'h1, 24'h000004, 16'h0000, 16'h0000, 4'h0, 2'h1, 1'h0}};
		repeat (5) @(negedge ref_clk);
		arst_n = 1'h1;
		chk(codeSeg === `CLBI_CS_RESET && instructionPointer === `CLBI_IP_RESET, "start point");
		for (i = 0; i < 12; i = i + 1)
		begin
			r = rows[i];
			base = opCount;
			send(r.t, r.s, r.w, r.a, r.d);
			if (r.rd)
				waitFor(0, 0);
			else
				waitFor(2, base + 1 + (r.w & r.a[0]));
			chk(!r.rd || rdData === r.e, "read data");
			chk(lastAddr[23:20] === r.top, "top nibble");
			chk({lastAddr[0], lastUbe} === r.ln, "lane code");
			chk({lastMio, lastCi} === {r.t != 3'h2 && r.t != 3'h3 && r.t != 3'h4, r.t < 3'h4}, "space code");
		end
		lat0 = cyc;
		readAt(`CLBI_SEG_DS, 24'h000004);
		lat0 = cyc - lat0;
		waits = 4'h3;
		base = cyc;
		readAt(`CLBI_SEG_DS, 24'h000004);
		chk(cyc - base >= lat0 + 4 && rdData === 16'h1234, "wait states");
		waits = 4'h0;
		csLoadValue = 16'h2000;
		@(negedge ref_clk) csReload = 1'h1;
		@(negedge ref_clk) csReload = 1'h0;
		readAt(`CLBI_SEG_CS, 24'h000010);
		chk(codeSeg === 16'h2000 && lastAddr[23:20] === 4'h0, "cs reload");
		holdReq = 1'h1;
		waitFor(1, 0);
		chk(busOe === 1'h0, "bus not floated");
		base = opCount;
		for (i = 0; i < 8; i = i + 1)
			send(`CLBI_OP_MEM_WR, `CLBI_SEG_DS, 1'h1, 24'(2 * i), 16'h00A0 + 16'(i));
		chk(reqReady === 1'h0 && opCount === base, "full queue or bus used in hold");
		holdReq = 1'h0;
		waitFor(2, base + 3);
		holdReq = 1'h1;
		waitFor(1, 0);
		holdReq = 1'h0;
		waitFor(2, base + 8);
		readAt(`CLBI_SEG_DS, 24'h000006);
		chk(rdData === 16'h00A3, "queued write");
		@(negedge ref_clk) peSet = 1'h1;
		@(negedge ref_clk) peSet = 1'h0;
		base = faultCount;
		repeat (2)
		begin
			@(negedge ref_clk) excEvent = 1'h1;
			@(negedge ref_clk) excEvent = 1'h0;
			@(negedge ref_clk) instrDone = 1'h1;
			@(negedge ref_clk) instrDone = 1'h0;
		end
		repeat (2)
		begin
			@(negedge ref_clk) excEvent = 1'h1;
			@(negedge ref_clk) excEvent = 1'h0;
		end
		waitFor(5, base + 1);
		chk(faultCount === base + 1, "double fault count");
		base = opCount;
		@(negedge ref_clk) excEvent = 1'h1;
		@(negedge ref_clk) excEvent = 1'h0;
		waitFor(3, 0);
		waitFor(2, base + 1);
		chk(lastAddr === `CLBI_SHUTDOWN_ADDR, "shutdown halt");
		nmiIn = 1'h1;
		waitFor(4, 0);
		chk(protMode === 1'h1, "mode lost on nmi");
		nmiIn = 1'h0;
		readAt(`CLBI_SEG_DS, 24'hA00010);
		chk(lastAddr[23:20] === 4'hA && rdData === 16'h5A08, "protected address");
		arst_n = 1'h0;
		repeat (2) @(negedge ref_clk);
		arst_n = 1'h1;
		chk(protMode === 1'h0 && codeSeg === `CLBI_CS_RESET && hold_grant_out === 1'h0, "second reset");
		readAt(`CLBI_SEG_CS, 24'h000010);
		chk(lastAddr[23:20] === `CLBI_TOP_HIGH, "top nibble after reset");
		tally_and_finish;
	end
endmodule
